// file: design/mau_consts.svh
`ifndef MAU_CONSTS_SVH
`define MAU_CONSTS_SVH
// ----------------------------------------------------------------------
// Datapath constants
// ----------------------------------------------------------------------
`define MAU_NUM_ACC     4
`define MAU_ACC_SEL_W   2
`define MAU_DATA_W      32
`define MAU_LATENCY     5
`define MAU_REPEAT      1
`define MAU_REG_IDX_W   5
`define MAU_OP_W        4
`define MAU_SHAMT_W     6
`define MAU_ACC_RESET   64'h0000_0000_0000_0000
`endif

// file: design/mau_pkg.sv
`include "mau_consts.svh"
package mau_pkg;
   typedef enum logic [`MAU_OP_W-1:0] {
      MAU_OP_NONE   = 4'h0,
      MAU_OP_MULT   = 4'h1,
      MAU_OP_MULTU  = 4'h2,
      MAU_OP_MULTIPLY_ADD_ACCUMULATE   = 4'h3,
      MAU_OP_MULTIPLY_SUBTRACT_ACCUMULATE   = 4'h4,
      MAU_OP_DIRECT = 4'h5,
      MAU_OP_DOTPQ  = 4'h6,
      MAU_OP_DOTPQS = 4'h7,
      MAU_OP_SHILO  = 4'h8,
      MAU_OP_MTHI   = 4'h9,
      MAU_OP_MTLO   = 4'hA,
      MAU_OP_DIV    = 4'hB,
      MAU_OP_DIVU   = 4'hC
   } mau_op_type;

   typedef struct packed {
      logic                        valid;
      mau_op_type                  op;
      logic [`MAU_ACC_SEL_W-1:0]   acc;
      logic [`MAU_REG_IDX_W-1:0]   dest;
      logic [`MAU_DATA_W-1:0]      rs;
      logic [`MAU_DATA_W-1:0]      rt;
      logic [`MAU_SHAMT_W-1:0]     shamt;
   } mau_req_type;

   typedef struct packed {
      logic                        valid;
      logic                        to_acc;
      logic [`MAU_ACC_SEL_W-1:0]   acc;
      logic [`MAU_REG_IDX_W-1:0]   dest;
      logic [2*`MAU_DATA_W-1:0]    value;
      logic                        sat;
   } mau_stage_type;

   typedef struct packed {
      logic                        valid;
      logic [`MAU_REG_IDX_W-1:0]   dest;
      logic [`MAU_DATA_W-1:0]      data;
   } mau_wb_type;
endpackage

// file: design/mau_unit.sv
// Behaviour
// RULE1 - Each multiply or divide result other than a direct multiply lands in one of four selected pairs.
// RULE2 - Moves from a high or low half return it for a register write.
// RULE3 - Direct multiply writes the product's low word straight to a register.
// RULE4 - Multiply-add adds the product to the selected 64-bit pair.
// RULE5 - Multiply-subtract subtracts the product from the selected pair.
// RULE6 - Pair shifts and signal-processing multiplies with their data types.
// RULE7 - Multiplies and dot products take five clocks, one new per clock.
// RULE8 - Stall readers of a pair or direct result while a write is pending.
`timescale 1ns/1ps
`include "mau_consts.svh"
module mau_unit
   import mau_pkg::*;
#(
   parameter int LATENCY = `MAU_LATENCY
) (
   input  wire logic                      clock,
   input  wire logic                      sys_rst,
   input  wire logic                      clk_en,
   input  wire mau_req_type               req,
   input  wire logic                      move_from_high_half,
   input  wire logic                      move_from_low_half,
   input  wire logic [`MAU_ACC_SEL_W-1:0] move_acc,
   input  wire logic [`MAU_REG_IDX_W-1:0] move_dest,
   input  wire logic                      gpr_read_valid,
   input  wire logic [`MAU_REG_IDX_W-1:0] gpr_read_idx,
   output logic                           req_ready,
   output logic                           stall,
   output mau_wb_type                     wb
);
   localparam int DW = `MAU_DATA_W;
   localparam int NA = `MAU_NUM_ACC;

   // -------------------------------------------------------------------
   // Accumulator pairs and pipeline state
   // -------------------------------------------------------------------
   logic [DW-1:0]   accumulator_high_half_q [NA];
   logic [DW-1:0]   accumulator_low_half_q  [NA];
   logic [DW-1:0]   accumulator_high_half_d [NA];
   logic [DW-1:0]   accumulator_low_half_d  [NA];
   mau_stage_type   pipe_q [LATENCY];
   mau_stage_type   pipe_d [LATENCY];
   mau_wb_type      wb_d;
   logic            move_hit;
   logic            acc_busy;
   logic            dest_busy;
   logic            src_busy;
   logic            port_busy;
   logic            issue;

   // -------------------------------------------------------------------
   // Hazard detection
   // -------------------------------------------------------------------
   function automatic logic acc_pending(input logic [`MAU_ACC_SEL_W-1:0] a);
      logic hit;
      hit = 1'b0;
      for (int i = 0; i < LATENCY; i++) begin
         if (pipe_q[i].valid && pipe_q[i].to_acc && pipe_q[i].acc == a) begin
            hit = 1'b1;
         end
      end
      return hit;
   endfunction

   function automatic logic
         reg_pending(input logic [`MAU_REG_IDX_W-1:0] r);
      logic hit;
      hit = 1'b0;
      for (int i = 0; i < LATENCY; i++) begin
         if (pipe_q[i].valid && !pipe_q[i].to_acc && pipe_q[i].dest == r) begin
            hit = 1'b1;
         end
      end
      return hit;
   endfunction

   // Moves into one half keep the other half as it stands at issue, so
   // they count as readers of the pair too.
   function automatic logic reads_acc(input mau_op_type op);
      return op inside {MAU_OP_MULTIPLY_ADD_ACCUMULATE, MAU_OP_MULTIPLY_SUBTRACT_ACCUMULATE, MAU_OP_DOTPQ,
                        MAU_OP_DOTPQS, MAU_OP_SHILO, MAU_OP_MTHI,
                        MAU_OP_MTLO};
   endfunction

   // Accumulating ops read the pair at issue, so a pending write to the
   // same pair must drain first; this trades throughput on back-to-back
   // accumulates to one pair for a simple single-read datapath.
   always_comb begin
      move_hit  = move_from_high_half || move_from_low_half;
      acc_busy  = move_hit && acc_pending(move_acc);                 // RULE8
      dest_busy = gpr_read_valid && reg_pending(gpr_read_idx);       // RULE8
      src_busy  = req.valid && reads_acc(req.op) &&
                  acc_pending(req.acc);                              // RULE8
      // A retiring direct multiply owns the write-back port, so a move in
      // that cycle is held off rather than silently lost.
      port_busy = move_hit && pipe_q[LATENCY-1].valid &&
                  !pipe_q[LATENCY-1].to_acc;                         // RULE2
      stall     = acc_busy || dest_busy || src_busy || port_busy;
      req_ready = !src_busy;                                         // RULE7
      issue     = req.valid && req_ready;
   end

   // -------------------------------------------------------------------
   // Operation datapath
   // -------------------------------------------------------------------
   function automatic logic [2*DW-1:0] sat_q31(input logic [2*DW-1:0] v);
      logic signed [2*DW-1:0] s;
      s = signed'(v);
      if (s > 64'sh0000_0000_7FFF_FFFF) begin
         return 64'h0000_0000_7FFF_FFFF;
      end else if (s < -64'sh0000_0000_8000_0000) begin
         return 64'hFFFF_FFFF_8000_0000;
      end
      return v;
   endfunction

   always_comb begin
      logic [2*DW-1:0] acc_now;
      logic [2*DW-1:0] prod_s;
      logic [2*DW-1:0] prod_u;
      logic [2*DW-1:0] dot;
      logic [DW-1:0]   hh;
      logic [DW-1:0]   ll;
      mau_stage_type   st;
      hh      = accumulator_high_half_q[req.acc];
      ll      = accumulator_low_half_q[req.acc];
      acc_now = {hh, ll};
      // Operands are widened first so no product is cut to operand width.
      prod_s  = 64'(signed'(req.rs)) * 64'(signed'(req.rt));
      prod_u  = 64'(req.rs) * 64'(req.rt);
      // Q15 pairs: two signed 16x16 products, each doubled.
      dot = 64'(signed'(req.rs[31:16])) * 64'(signed'(req.rt[31:16]))
          + 64'(signed'(req.rs[15:0])) * 64'(signed'(req.rt[15:0]));
      dot = {dot[2*DW-2:0], 1'b0};
      st        = '0;
      st.valid  = issue && req.op != MAU_OP_NONE;
      st.to_acc = req.op != MAU_OP_DIRECT;                           // RULE1
      st.acc    = req.acc;
      st.dest   = req.dest;
      unique case (req.op)
         MAU_OP_MULT:   st.value = prod_s;                          // RULE1
         MAU_OP_MULTU:  st.value = prod_u;
         MAU_OP_MULTIPLY_ADD_ACCUMULATE:   st.value = acc_now + prod_s;                // RULE4
         MAU_OP_MULTIPLY_SUBTRACT_ACCUMULATE:   st.value = acc_now - prod_s;                // RULE5
         MAU_OP_DIRECT: st.value = prod_s;                          // RULE3
         MAU_OP_DOTPQ:  st.value = acc_now + dot;                   // RULE6
         MAU_OP_DOTPQS: begin
            st.value = acc_now + dot;                               // RULE6
            st.sat   = 1'b1;
         end
         MAU_OP_SHILO: begin
            if (req.shamt[5]) begin
               st.value = acc_now << (~req.shamt + 6'h01);          // RULE6
            end else begin
               st.value = acc_now >> req.shamt;
            end
         end
         MAU_OP_MTHI:   st.value = {req.rs, ll};
         MAU_OP_MTLO:   st.value = {hh, req.rs};
         MAU_OP_DIV: begin
            st.value = (req.rt == '0) ? '0 :
               {DW'(signed'(req.rs) % signed'(req.rt)),
                DW'(signed'(req.rs) / signed'(req.rt))};            // RULE1
         end
         MAU_OP_DIVU: begin
            st.value = (req.rt == '0) ? '0 :
               {req.rs % req.rt, req.rs / req.rt};
         end
         default:       st.value = '0;
      endcase
      pipe_d[0] = st;
      for (int i = 1; i < LATENCY; i++) begin
         pipe_d[i] = pipe_q[i-1];                                   // RULE7
      end
   end

   // -------------------------------------------------------------------
   // Retirement and register write-back
   // -------------------------------------------------------------------
   always_comb begin
      mau_stage_type    rt_s;
      logic [2*DW-1:0]  v;
      rt_s = pipe_q[LATENCY-1];
      v    = rt_s.sat ? sat_q31(rt_s.value) : rt_s.value;
      for (int i = 0; i < NA; i++) begin
         accumulator_high_half_d[i] = accumulator_high_half_q[i];
         accumulator_low_half_d[i]  = accumulator_low_half_q[i];
      end
      wb_d = '0;
      if (rt_s.valid && rt_s.to_acc) begin
         accumulator_high_half_d[rt_s.acc] = v[2*DW-1:DW];          // RULE1
         accumulator_low_half_d[rt_s.acc]  = v[DW-1:0];
      end
      // A retiring direct multiply owns the port; moves stall behind it.
      if (rt_s.valid && !rt_s.to_acc) begin
         wb_d.valid = 1'b1;                                          // RULE3
         wb_d.dest  = rt_s.dest;
         wb_d.data  = v[DW-1:0];
      end else if (move_hit && !acc_busy) begin
         wb_d.valid = 1'b1;                                          // RULE2
         wb_d.dest  = move_dest;
         wb_d.data  = move_from_high_half ?
                      accumulator_high_half_q[move_acc] :
                      accumulator_low_half_q[move_acc];
      end
   end

   always_ff @(posedge clock) begin
      if (sys_rst) begin
         for (int i = 0; i < NA; i++) begin
            accumulator_high_half_q[i] <= DW'(`MAU_ACC_RESET >> DW);
            accumulator_low_half_q[i]  <= DW'(`MAU_ACC_RESET);
         end
         for (int i = 0; i < LATENCY; i++) begin
            pipe_q[i] <= '0;
         end
         wb <= '0;
      end else if (clk_en) begin
         accumulator_high_half_q <= accumulator_high_half_d;
         accumulator_low_half_q  <= accumulator_low_half_d;
         pipe_q                  <= pipe_d;
         wb                      <= wb_d;
      end
   end
endmodule

// file: verif/mau_core_model.sv
`timescale 1ns/1ps
module mau_core_model
   import mau_pkg::*;
(
   input wire logic       clock,
   input wire logic       sys_rst,
   input wire mau_wb_type wb,
   output logic [31:0]    last_data_q,
   output logic [7:0]     writes_q
);
   logic [31:0] last_data_d;
   logic [7:0]  writes_d;
   // The pipeline's register file keeps the last write-back it is handed and counts every one.
   always_comb begin
      last_data_d = wb.valid ? wb.data : last_data_q;
      writes_d = writes_q + {7'h00, wb.valid};
   end
   always_ff @(posedge clock) begin
      last_data_q <= sys_rst ? 32'h0 : last_data_d;
      writes_q <= sys_rst ? 8'h00 : writes_d;
   end
endmodule

// file: verif/mau_unit_sva.sv
`timescale 1ns/1ps
`include "mau_consts.svh"
module mau_unit_sva
   import mau_pkg::*;
#(
   parameter int LATENCY = `MAU_LATENCY
) (
   input wire logic                      clock,
   input wire logic                      sys_rst,
   input wire logic                      clk_en,
   input wire mau_req_type               req,
   input wire logic                      move_from_high_half,
   input wire logic                      move_from_low_half,
   input wire logic [`MAU_ACC_SEL_W-1:0] move_acc,
   input wire logic [`MAU_REG_IDX_W-1:0] move_dest,
   input wire logic                      gpr_read_valid,
   input wire logic [`MAU_REG_IDX_W-1:0] gpr_read_idx,
   input wire logic                      req_ready,
   input wire logic                      stall,
   input wire mau_wb_type                wb
);
   localparam int WB_DLY = LATENCY + 1;
   logic       take_acc;
   logic       take_dir;
   logic       mv;
   logic [7:0] idle_q;
   logic [7:0] idle_d;
   default clocking @(posedge clock); endclocking
   default disable iff (sys_rst);
   assign take_acc = clk_en && req.valid && req_ready && req.op inside
                     {MAU_OP_MULT, MAU_OP_MULTIPLY_ADD_ACCUMULATE, MAU_OP_MULTIPLY_SUBTRACT_ACCUMULATE};
   assign take_dir = clk_en && req.valid && req_ready &&
                     req.op == MAU_OP_DIRECT;
   assign mv = clk_en && (move_from_high_half || move_from_low_half) && !stall;
   // A long quiet spell means nothing can still be pending.
   always_comb begin
      idle_d = idle_q;
      if (req.valid) idle_d = 8'h00;
      else if (clk_en && idle_q != 8'hFF) idle_d = idle_q + 8'h01;
   end
   always_ff @(posedge clock) begin
      idle_q <= sys_rst ? 8'h00 : idle_d;
   end
   dir_latency_a: assert property (
      take_dir ##1 clk_en[*5] |=> wb.valid &&
      wb.dest == $past(req.dest, WB_DLY) && wb.data ==
      32'($past(req.rs, WB_DLY) * $past(req.rt, WB_DLY)))
      else $error("direct multiply write-back wrong");
   move_wb_a: assert property (
      mv |=> wb.valid && wb.dest == $past(move_dest))
      else $error("move gave no write-back");
   wb_cause_a: assert property (wb.valid && $past(clk_en) |->
      $past(mv) || $past(take_dir, WB_DLY)) else $error("stray write-back");
   move_hazard_a: assert property (take_acc ##1 (clk_en &&
      (move_from_high_half || move_from_low_half) &&
      move_acc == $past(req.acc)) |-> stall) else $error("move not stalled");
   acc_hazard_a: assert property (take_acc ##1 (req.valid &&
      req.op inside {MAU_OP_MULTIPLY_ADD_ACCUMULATE, MAU_OP_MULTIPLY_SUBTRACT_ACCUMULATE} && req.acc == $past(req.acc))
      |-> !req_ready && stall) else $error("accumulate not refused");
   gpr_hazard_a: assert property (take_dir ##1 (gpr_read_valid &&
      gpr_read_idx == $past(req.dest)) |-> stall) else $error("read not held");
   reset_clear_a: assert property (disable iff (1'b0) sys_rst |=> !wb.valid)
      else $error("write-back during reset");
   idle_free_a: assert property (
      idle_q > 8'(LATENCY) |-> !stall && req_ready)
      else $error("stall with nothing pending");
   freeze_a: assert property (!clk_en |=> $stable(wb)) else $error("not frozen");
   cover property (take_dir ##1 clk_en[*5] ##1 wb.valid);
   cover property (req.valid && !req_ready);
   cover property (mv ##1 wb.valid);
endmodule

// file: verif/multiply_accumulate_unit_test.sv
`timescale 1ns/1ps
`include "mau_consts.svh"
module multiply_accumulate_unit_test;
   import mau_pkg::*;
   localparam int LAT = 5;
   logic        clock, sys_rst, clk_en, mv_hi, mv_lo, gpr_rv, req_ready, stall;
   logic [1:0]  mv_acc;
   logic [4:0]  gpr_idx;
   logic [4:0]  mv_dest;
   logic [7:0]  writes;
   logic [31:0] last_data;
   mau_req_type req;
   mau_wb_type  wb;
   int          mismatches, samples_checked, n;
   longint      e;
   mau_unit #(.LATENCY(LAT)) mau_unit_i (.clock(clock), .sys_rst(sys_rst),
      .clk_en(clk_en), .req(req), .move_from_high_half(mv_hi),
      .move_from_low_half(mv_lo), .move_acc(mv_acc), .move_dest(mv_dest),
      .gpr_read_valid(gpr_rv), .gpr_read_idx(gpr_idx),
      .req_ready(req_ready), .stall(stall), .wb(wb));
   mau_core_model mau_core_model_i (.clock(clock), .sys_rst(sys_rst),
      .wb(wb), .last_data_q(last_data), .writes_q(writes));
   always #12.5 clock = ~clock;
   task automatic check(input string what, input logic [63:0] seen, exp);
      samples_checked++;
      if (seen !== exp) begin
         mismatches++;
         $display("Error %s expected %h seen %h", what, exp, seen);
      end
   endtask
   // Holds the request until taken; n counts refused cycles.
   task automatic issue(input mau_op_type op, input logic [1:0] acc,
                        input logic [31:0] rs, rt, input logic [5:0] sh);
      req = '{1'b1, op, acc, 5'h09, rs, rt, sh};
      n = 0;
      #1;
      while (req_ready !== 1'b1 && n < 50) begin
         @(negedge clock);
         #1;
         n++;
      end
      @(negedge clock);
   endtask
   task automatic move(input logic hi, input logic [1:0] acc,
                       input logic [31:0] exp);
      req.valid = 1'b0;
      mv_hi = hi;
      mv_lo = !hi;
      mv_acc = acc;
      mv_dest = {2'h2, hi, acc};
      n = 0;
      #1;
      while (stall !== 1'b0 && n < 50) begin
         @(negedge clock);
         #1;
         n++;
      end
      @(negedge clock);
      check("move", {27'h0, wb.dest, wb.data},
            {27'h0, 2'h2, hi, acc, exp});
      mv_hi = 1'b0;
      mv_lo = 1'b0;
      @(negedge clock);
   endtask
   task automatic t_mult;
      for (int k = 0; k < 4; k++) begin
         issue(MAU_OP_MULT, 2'(k), 32'hFFFF_FFFD, 32'(k + 5), 6'h00);
         check("refused", 64'(n), 64'h0);
      end
      move(1'b0, 2'h3, 32'hFFFF_FFE8);
      check("pending stall", 64'(n), 64'(LAT));
      for (int k = 0; k < 4; k++) begin
         e = -3 * (k + 5);
         move(1'b1, 2'(k), e[63:32]);
         move(1'b0, 2'(k), e[31:0]);
      end
   endtask
   task automatic t_acc;
      issue(MAU_OP_MULTIPLY_ADD_ACCUMULATE, 2'h1, 32'h4, 32'h5, 6'h00);
      issue(MAU_OP_MULTIPLY_SUBTRACT_ACCUMULATE, 2'h1, 32'h3, 32'h2, 6'h00);
      check("drain wait", 64'(n), 64'(LAT));
      move(1'b1, 2'h1, 32'hFFFF_FFFF);
      move(1'b0, 2'h1, 32'hFFFF_FFFC);
   endtask
   task automatic t_direct;
      issue(MAU_OP_DIRECT, 2'h0, 32'h0001_2345, 32'h0000_0100, 6'h00);
      req.valid = 1'b0;
      gpr_rv = 1'b1;
      gpr_idx = 5'h09;
      #1;
      check("read stall", {63'h0, stall}, 64'h1);
      n = 0;
      while (wb.valid !== 1'b1 && n < 20) begin
         @(negedge clock);
         n++;
      end
      check("latency", 64'(n), 64'(LAT));
      check("direct", {27'h0, wb.dest, wb.data},
            {27'h0, 5'h09, 32'h0123_4500});
      gpr_rv = 1'b0;
      @(negedge clock);
      check("register file", {32'h0, last_data}, 64'h0123_4500);
      check("write count", {56'h0, writes}, 64'h0D);
   endtask
   task automatic t_shift;
      issue(MAU_OP_SHILO, 2'h2, 32'h0, 32'h0, 6'h04);
      req.valid = 1'b0;
      clk_en = 1'b0;
      repeat (3) @(negedge clock);
      clk_en = 1'b1;
      move(1'b1, 2'h2, 32'h0FFF_FFFF);
      move(1'b0, 2'h2, 32'hFFFF_FFFE);
   endtask
   task automatic t_dsp;
      issue(MAU_OP_MULTU, 2'h0, 32'hFFFF_FFFF, 32'h0000_0002, 6'h00);
      check("multu taken", 64'(n), 64'h0);
      issue(MAU_OP_DIVU, 2'h1, 32'h0000_0064, 32'h0000_0007, 6'h00);
      check("divu taken", 64'(n), 64'h0);
      issue(MAU_OP_DIV, 2'h2, 32'hFFFF_FFF9, 32'h0000_0002, 6'h00);
      check("div taken", 64'(n), 64'h0);
      move(1'b1, 2'h0, 32'h0000_0001);
      move(1'b0, 2'h0, 32'hFFFF_FFFE);
      move(1'b1, 2'h1, 32'h0000_0002);
      move(1'b0, 2'h1, 32'h0000_000E);
      move(1'b1, 2'h2, 32'hFFFF_FFFF);
      move(1'b0, 2'h2, 32'hFFFF_FFFD);
      issue(MAU_OP_MTHI, 2'h3, 32'h0000_0000, 32'h0000_0000, 6'h00);
      issue(MAU_OP_MTLO, 2'h3, 32'h0000_0010, 32'h0000_0000, 6'h00);
      check("half write wait", 64'(n), 64'(LAT));
      issue(MAU_OP_DOTPQ, 2'h3, 32'h0002_FFFF, 32'h0003_0004, 6'h00);
      move(1'b0, 2'h3, 32'h0000_0014);
      issue(MAU_OP_DOTPQS, 2'h3, 32'h7FFF_7FFF, 32'h7FFF_7FFF, 6'h00);
      move(1'b1, 2'h3, 32'h0000_0000);
      move(1'b0, 2'h3, 32'h7FFF_FFFF);
      issue(MAU_OP_SHILO, 2'h3, 32'h0000_0000, 32'h0000_0000, 6'h3C);
      move(1'b1, 2'h3, 32'h0000_0007);
      move(1'b0, 2'h3, 32'hFFFF_FFF0);
      // A reset in mid-run must flush the pending multiply.
      issue(MAU_OP_MULT, 2'h0, 32'h0000_0005, 32'h0000_0005, 6'h00);
      req.valid = 1'b0;
      sys_rst = 1'b1;
      repeat (2) @(negedge clock);
      sys_rst = 1'b0;
      check("reset idle", {62'h0, wb.valid, stall}, 64'h0);
      move(1'b0, 2'h0, 32'h0000_0000);
      check("reset flush", 64'(n), 64'h0);
   endtask
   task automatic complete_run;
      $display("comparisons %0d mismatches %0d", samples_checked, mismatches);
      if (mismatches == 0 && samples_checked > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   initial begin
      #(1500 * 25);
      mismatches++;
      complete_run();
   end
   initial begin
      {clock, mv_hi, mv_lo, gpr_rv, mv_acc, gpr_idx, mv_dest} = '0;
      req = '0;
      sys_rst = 1'b1;
      clk_en = 1'b1;
      repeat (3) @(negedge clock);
      sys_rst = 1'b0;
      check("idle", {62'h0, wb.valid, stall}, 64'h0);
      move(1'b0, 2'h3, 32'h0);
      t_mult();
      t_acc();
      t_direct();
      t_shift();
      t_dsp();
      complete_run();
   end
endmodule
bind mau_unit mau_unit_sva #(.LATENCY(LATENCY)) mau_unit_sva_i (
   .clock(clock), .sys_rst(sys_rst), .clk_en(clk_en), .req(req),
   .move_from_high_half(move_from_high_half),
   .move_from_low_half(move_from_low_half), .move_acc(move_acc),
   .move_dest(move_dest), .gpr_read_valid(gpr_read_valid),
   .gpr_read_idx(gpr_read_idx), .req_ready(req_ready), .stall(stall),
   .wb(wb));
